// ===== rtl/scan_adc_pkg.sv
// constants and types shared by the converter scan ends
// ==========================================================
package scan_adc_pkg;
	// ==========================================================
	// widths
	localparam int VALUE_W = 10;
	localparam int CHAN_N  = 8;
	localparam int MINUS_W = 3;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;

	// ==========================================================
	// codes and idle values
	localparam logic [VALUE_W-1:0] MID_CODE     = 10'h200;
	localparam logic [CHAN_N-1:0]  IDLE_CHANNEL = 8'h01;
	localparam logic [MINUS_W-1:0] IDLE_MINUS   = 3'h0;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int ENABLE_TIME_NS = 200;
	localparam int ENABLE_CYCLES  = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CYCLES    = 4;

	// ==========================================================
	// controller register offsets and fields
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
	localparam logic [ADDR_W-1:0] CHANNEL_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] LOW_OFS     = 8'h08;
	localparam logic [ADDR_W-1:0] HIGH_OFS    = 8'h0c;
	localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h10;
	localparam int CTRL_START_BIT  = 0;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_DONE_BIT     = 1;
	localparam int ST_PASS_BIT     = 2;
	localparam int ST_LOW_OK_BIT   = 3;
	localparam int ST_HIGH_OK_BIT  = 4;
	localparam logic [2:0]        CHANNEL_RESET = 3'h0;
	localparam logic [VALUE_W-1:0] LOW_RESET    = 10'h000;
	localparam logic [VALUE_W-1:0] HIGH_RESET   = 10'h3ff;

	// ==========================================================
	// reference source codes seen at the device user side
	localparam logic [1:0] REF_EXTERNAL = 2'h0;
	localparam logic [1:0] REF_BANDGAP  = 2'h1;
	localparam logic [1:0] REF_SUPPLY   = 2'h2;

	// limit check sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_WARM, S_SAMPLE, S_FREEZE, S_APPLY, S_PRESET, S_RELEASE
	} check_state_t;
endpackage : scan_adc_pkg

// ===== rtl/converter_scan_if.sv
// scan-cell signal set between test controller and converter
`timescale 1ns/1ps
`default_nettype none
interface converter_scan_if;
	logic                                sample_freeze;          // low tracks, high holds
	logic                                latch_preset_n;         // low presets decision latch
	logic [scan_adc_pkg::CHAN_N-1:0]     channel_select_onehot;  // positive input channel
	logic [scan_adc_pkg::MINUS_W-1:0]    minus_input_pick;       // differential minus mux
	logic                                bandgap_dac_ref_on;     // bandgap as reference
	logic                                supply_ref_pick;        // supply as reference
	logic                                gain_bypass_gate;       // gain stage pass gate
	logic                                gain_power_on;          // gain stages powered
	logic                                settle_boost;           // faster gain settling
	logic                                gain_switch_clk;        // gain stage switch clock
	logic                                gain_path_on;           // gain output to comparator
	logic                                bandgap_minus_on;       // bandgap as minus input
	logic                                ground_minus_on;        // ground as minus input
	logic                                converter_on;           // converter power
	logic                                switchcap_probe_en;     // gain output to probe pin
	logic [scan_adc_pkg::VALUE_W-1:0]    limit_value;            // ten-bit compare value
	logic                                sar_decision_out;       // comparator decision

	// test controller end
	modport ctrl (
		output sample_freeze, latch_preset_n, channel_select_onehot, minus_input_pick,
		output bandgap_dac_ref_on, supply_ref_pick, gain_bypass_gate, gain_power_on,
		output settle_boost, gain_switch_clk, gain_path_on, bandgap_minus_on,
		output ground_minus_on, converter_on, switchcap_probe_en, limit_value,
		input  sar_decision_out
	);
	// converter end
	modport conv (
		input  sample_freeze, latch_preset_n, channel_select_onehot, minus_input_pick,
		input  bandgap_dac_ref_on, supply_ref_pick, gain_bypass_gate, gain_power_on,
		input  settle_boost, gain_switch_clk, gain_path_on, bandgap_minus_on,
		input  ground_minus_on, converter_on, switchcap_probe_en, limit_value,
		output sar_decision_out
	);
endinterface : converter_scan_if
`default_nettype wire

// ===== rtl/converter_scan_end.sv
// converter end: sample and hold, decision latch, reference and mux state
`timescale 1ns/1ps
`default_nettype none
module converter_scan_end #(
	parameter int VALUE_W = scan_adc_pkg::VALUE_W,
	parameter int CHAN_N  = scan_adc_pkg::CHAN_N
) (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       ce,
	converter_scan_if.conv                  link,
	input  wire logic [CHAN_N*VALUE_W-1:0]  channel_levels,   // analog level per channel, as a code
	output logic      [VALUE_W-1:0]         held_level,       // level on the hold capacitor
	output logic      [1:0]                 ref_source,       // active reference
	output logic      [scan_adc_pkg::MINUS_W-1:0] minus_pick, // minus mux setting
	output logic                            pass_gate_on,     // gain pass gate state
	output logic                            probe_drive,      // gain output sent to probe
	output logic                            minus_contention, // more than one minus source
	output logic                            warm              // enable time elapsed
);
	// ==========================================================
	// positive input mux: or of all selected channels
	logic [VALUE_W-1:0] picked [CHAN_N+1];
	assign picked[0] = '0;
	genvar g;
	generate
		for (g = 0; g < CHAN_N; g++) begin : g_mux
			assign picked[g+1] = picked[g] | (link.channel_select_onehot[g] ? channel_levels[g*VALUE_W +: VALUE_W] : '0);
		end
	endgenerate

	logic [VALUE_W-1:0] held_reg;
	logic               resolved_reg;
	logic               decision_reg;
	logic [3:0]         warm_cnt_reg;   // counts enable time after power on
	logic               warm_reg;
	logic [1:0]         minus_count;    // number of minus sources driven

	assign minus_count = 2'(link.ground_minus_on) + 2'(link.bandgap_minus_on) + 2'(|link.minus_input_pick);

	// ==========================================================
	// sample and hold
	always_ff @(posedge clk) begin
		if (!rstn) begin
			held_reg <= '0;
		end else if (ce && !link.sample_freeze) begin
			held_reg <= picked[CHAN_N];
		end
	end

	// power-on settling time; decisions before it are not trusted
	always_ff @(posedge clk) begin
		if (!rstn || (ce && !link.converter_on)) begin
			warm_cnt_reg <= '0;
			warm_reg     <= 1'b0;
		end else if (ce && !warm_reg) begin
			warm_cnt_reg <= warm_cnt_reg + 4'h1;
			warm_reg     <= (warm_cnt_reg == 4'(scan_adc_pkg::ENABLE_CYCLES - 1));
		end
	end

	// ==========================================================
	// decision latch: preset low, resolve once after release
	always_ff @(posedge clk) begin
		if (!rstn) begin
			decision_reg <= 1'b0;
			resolved_reg <= 1'b0;
		end else if (ce) begin
			if (!link.latch_preset_n || !link.converter_on) begin
				decision_reg <= 1'b0;
				resolved_reg <= 1'b0;
			end else if (!resolved_reg && warm_reg) begin
				// high when the compare value lies above the held input
				decision_reg <= (link.limit_value > held_reg);
				resolved_reg <= 1'b1;
			end
		end
	end
	assign link.sar_decision_out = decision_reg;

	// ==========================================================
	// user-side status, all registered
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ref_source       <= scan_adc_pkg::REF_EXTERNAL;
			minus_pick       <= scan_adc_pkg::IDLE_MINUS;
			pass_gate_on     <= 1'b0;
			probe_drive      <= 1'b0;
			minus_contention <= 1'b0;
		end else if (ce) begin
			// supply pick wins over the bandgap reference
			if (link.supply_ref_pick) begin
				ref_source <= scan_adc_pkg::REF_SUPPLY;
			end else if (link.bandgap_dac_ref_on) begin
				ref_source <= scan_adc_pkg::REF_BANDGAP;
			end else begin
				ref_source <= scan_adc_pkg::REF_EXTERNAL;
			end
			minus_pick       <= link.minus_input_pick;
			pass_gate_on     <= link.gain_bypass_gate;
			probe_drive      <= link.switchcap_probe_en & link.gain_power_on;
			minus_contention <= (minus_count > 2'h1);
		end
	end
	assign held_level = held_reg;
	assign warm       = warm_reg;
endmodule : converter_scan_end
`default_nettype wire

// ===== rtl/scan_check_controller.sv
// test controller end: runs a two-limit check through the scan signals
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module scan_check_controller #(
	parameter int VALUE_W     = scan_adc_pkg::VALUE_W,
	parameter int CHAN_N      = scan_adc_pkg::CHAN_N,
	parameter int STEP_CYCLES = scan_adc_pkg::STEP_CYCLES
) (
	input  wire logic                              clk,
	input  wire logic                              rstn,
	input  wire logic                              ce,
	converter_scan_if.ctrl                         link,
	input  wire logic [scan_adc_pkg::ADDR_W-1:0]   addr,
	input  wire logic [scan_adc_pkg::DATA_W-1:0]   wr_data,
	input  wire logic                              wr_en,
	input  wire logic                              rd_en,
	output logic      [scan_adc_pkg::DATA_W-1:0]   rd_data
);
	// ==========================================================
	// software registers
	logic [2:0]         channel_reg;   // channel index under test
	logic [VALUE_W-1:0] low_reg;       // lower limit code
	logic [VALUE_W-1:0] high_reg;      // upper limit code
	logic               done_reg;      // sticky end of check
	logic               low_ok_reg;    // lower limit decision read low
	logic               high_ok_reg;   // upper limit decision read high
	logic               start;         // software start strobe

	// a start while busy is dropped by the sequencer, so no check is cut short
	assign start = wr_en && (addr == scan_adc_pkg::CTRL_OFS) && wr_data[scan_adc_pkg::CTRL_START_BIT];

	// ==========================================================
	// sequencer state
	scan_adc_pkg::check_state_t state_reg;
	logic [7:0]                 step_cnt_reg;  // cycles left in the current step
	logic                       upper_reg;     // second phase: upper limit
	logic                       step_end;

	assign step_end = (step_cnt_reg == 8'h00);

	// ==========================================================
	// limit settings, written only while idle so a check sees stable limits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			channel_reg <= scan_adc_pkg::CHANNEL_RESET;
			low_reg     <= scan_adc_pkg::LOW_RESET;
			high_reg    <= scan_adc_pkg::HIGH_RESET;
		end else if (ce && wr_en && state_reg == scan_adc_pkg::S_IDLE) begin
			// writes while busy are dropped without any error flag
			if (addr == scan_adc_pkg::CHANNEL_OFS) begin
				channel_reg <= wr_data[2:0];
			end
			if (addr == scan_adc_pkg::LOW_OFS) begin
				low_reg <= wr_data[VALUE_W-1:0];
			end
			if (addr == scan_adc_pkg::HIGH_OFS) begin
				high_reg <= wr_data[VALUE_W-1:0];
			end
		end
	end

	// register read, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_data <= '0;
		end else if (ce) begin
			// data stand one cycle only, then fall back to zero
			rd_data <= '0;
			if (rd_en) begin
				unique case (addr)
					scan_adc_pkg::CHANNEL_OFS: rd_data <= 32'(channel_reg);
					scan_adc_pkg::LOW_OFS:     rd_data <= 32'(low_reg);
					scan_adc_pkg::HIGH_OFS:    rd_data <= 32'(high_reg);
					scan_adc_pkg::STATUS_OFS: begin
						rd_data[scan_adc_pkg::ST_BUSY_BIT]    <= (state_reg != scan_adc_pkg::S_IDLE);
						rd_data[scan_adc_pkg::ST_DONE_BIT]    <= done_reg;
						rd_data[scan_adc_pkg::ST_PASS_BIT]    <= done_reg & low_ok_reg & high_ok_reg;
						rd_data[scan_adc_pkg::ST_LOW_OK_BIT]  <= low_ok_reg;
						rd_data[scan_adc_pkg::ST_HIGH_OK_BIT] <= high_ok_reg;
					end
					default: rd_data <= '0;
				endcase
			end
		end
	end

	// ==========================================================
	// step sequencer: one state per scan update of the check
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg    <= scan_adc_pkg::S_IDLE;
			step_cnt_reg <= '0;
			upper_reg    <= 1'b0;
		end else if (ce) begin
			// count the current step down; a state change below reloads it
			if (!step_end) begin
				step_cnt_reg <= step_cnt_reg - 8'h01;
			end
			unique case (state_reg)
				// wait for software to start a check
				scan_adc_pkg::S_IDLE: begin
					if (start) begin
						state_reg    <= scan_adc_pkg::S_WARM;
						step_cnt_reg <= 8'(scan_adc_pkg::ENABLE_CYCLES - 1);
						upper_reg    <= 1'b0;
					end
				end
				// power-up time of the converter before the sample step; channel select and ground minus are already driven
				scan_adc_pkg::S_WARM: begin
					if (step_end) begin
						state_reg    <= scan_adc_pkg::S_SAMPLE;
						step_cnt_reg <= 8'(STEP_CYCLES - 1);
					end
				end
				// sample, freeze, apply and preset each last one step
				scan_adc_pkg::S_SAMPLE, scan_adc_pkg::S_FREEZE,
				scan_adc_pkg::S_APPLY, scan_adc_pkg::S_PRESET: begin
					if (step_end) begin
						state_reg    <= scan_adc_pkg::check_state_t'(state_reg + 3'h1);
						step_cnt_reg <= 8'(STEP_CYCLES - 1);
					end
				end
				scan_adc_pkg::S_RELEASE: begin
					if (step_end) begin
						// lower phase first, then the upper phase
						state_reg    <= upper_reg ? scan_adc_pkg::S_IDLE : scan_adc_pkg::S_SAMPLE;
						upper_reg    <= ~upper_reg;
						step_cnt_reg <= 8'(STEP_CYCLES - 1);
					end
				end
			endcase
		end
	end

	// ==========================================================
	// result capture at the end of the release step only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			done_reg    <= 1'b0;
			low_ok_reg  <= 1'b0;
			high_ok_reg <= 1'b0;
		end else if (ce) begin
			if (start && state_reg == scan_adc_pkg::S_IDLE) begin
				done_reg    <= 1'b0;
				low_ok_reg  <= 1'b0;
				high_ok_reg <= 1'b0;
			end else if (state_reg == scan_adc_pkg::S_RELEASE && step_end) begin
				// the decision resolved two cycles earlier, so it has settled here
				if (upper_reg) begin
					high_ok_reg <= link.sar_decision_out;
					done_reg    <= 1'b1;
				end else begin
					low_ok_reg  <= !link.sar_decision_out;
				end
			end
		end
	end

	// ==========================================================
	// scan signal drive; idle values whenever no check runs
	logic active;   // a check is running
	assign active = (state_reg != scan_adc_pkg::S_IDLE);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.converter_on          <= 1'b0;
			link.sample_freeze         <= 1'b1;
			link.latch_preset_n        <= 1'b1;
			link.channel_select_onehot <= scan_adc_pkg::IDLE_CHANNEL;
			link.limit_value           <= scan_adc_pkg::MID_CODE;
			link.ground_minus_on       <= 1'b0;
		end else if (ce) begin
			link.converter_on          <= active;
			link.channel_select_onehot <= active ? CHAN_N'(1) << channel_reg : scan_adc_pkg::IDLE_CHANNEL;
			// ground is the single minus source while checking
			link.ground_minus_on       <= active;
			// freeze is low in the sample step only, where the value is midpoint
			link.sample_freeze         <= (state_reg != scan_adc_pkg::S_SAMPLE);
			link.latch_preset_n        <= (state_reg != scan_adc_pkg::S_PRESET);
			// limit stands from apply until the decision has been taken
			unique case (state_reg)
				scan_adc_pkg::S_APPLY, scan_adc_pkg::S_PRESET, scan_adc_pkg::S_RELEASE:
					link.limit_value <= upper_reg ? high_reg : low_reg;
				default:
					link.limit_value <= scan_adc_pkg::MID_CODE;
			endcase
		end
	end

	// gain stages, references and minus mux are never exercised here
	// limitation: a check of the gain path or other references needs more controls
	// these flops only take their reset values and then hold them
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link.minus_input_pick   <= scan_adc_pkg::IDLE_MINUS;
			link.bandgap_dac_ref_on <= 1'b0;
			link.supply_ref_pick    <= 1'b0;
			link.gain_bypass_gate   <= 1'b1;
			link.gain_power_on      <= 1'b0;
			link.settle_boost       <= 1'b0;
			link.gain_switch_clk    <= 1'b0;
			link.gain_path_on       <= 1'b0;
			link.bandgap_minus_on   <= 1'b0;
			link.switchcap_probe_en <= 1'b0;
		end
	end
endmodule : scan_check_controller
`default_nettype wire

// ===== verif/scan_adc_assertions.sv
// concurrent checks on the scan signals between the two converter ends
`timescale 1ns/1ps
`default_nettype none
module scan_adc_assertions (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       sample_freeze,
	input wire logic       latch_preset_n,
	input wire logic [7:0] channel_select_onehot,
	input wire logic [2:0] minus_input_pick,
	input wire logic       bandgap_dac_ref_on,
	input wire logic       supply_ref_pick,
	input wire logic       gain_bypass_gate,
	input wire logic       gain_power_on,
	input wire logic       settle_boost,
	input wire logic       gain_switch_clk,
	input wire logic       gain_path_on,
	input wire logic       bandgap_minus_on,
	input wire logic       ground_minus_on,
	input wire logic       converter_on,
	input wire logic       switchcap_probe_en,
	input wire logic [9:0] limit_value,
	input wire logic       sar_decision_out
);
	// ==========================================================
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// properties
	property p_idle_values;
		!converter_on |-> sample_freeze && latch_preset_n && channel_select_onehot == 8'h01 && limit_value == 10'h200
			&& gain_bypass_gate && minus_input_pick == 3'h0 && !supply_ref_pick && !bandgap_dac_ref_on;
	endproperty
	a_idle_values: assert property (p_idle_values) else $error("idle scan values wrong");
	property p_mid_sampling;
		!sample_freeze |-> limit_value == 10'h200 && converter_on;
	endproperty
	a_mid_sampling: assert property (p_mid_sampling) else $error("value not midpoint while sampling");
	property p_minus_single;
		converter_on |-> $onehot({ground_minus_on, bandgap_minus_on, |minus_input_pick});
	endproperty
	a_minus_single: assert property (p_minus_single) else $error("minus input not a single source");
	// gain stages are never touched, so clock and boost stay low as well
	property p_no_gain;
		!(gain_power_on | gain_path_on | switchcap_probe_en | settle_boost | gain_switch_clk);
	endproperty
	a_no_gain: assert property (p_no_gain) else $error("gain stage signal active");
	// enable time of ten cycles passes before sampling starts
	property p_warm_wait;
		$rose(converter_on) |-> sample_freeze[*8] ##1 sample_freeze[*2] ##1 !sample_freeze;
	endproperty
	a_warm_wait: assert property (p_warm_wait) else $error("sampling before enable time");
	property p_sample_len;
		$fell(sample_freeze) |-> !sample_freeze[*4] ##1 sample_freeze;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling phase length wrong");
	property p_preset_len;
		$fell(latch_preset_n) |-> (!latch_preset_n && sample_freeze)[*4] ##1 latch_preset_n;
	endproperty
	a_preset_len: assert property (p_preset_len) else $error("preset phase wrong");
	property p_preset_clears;
		!latch_preset_n || !converter_on |=> !sar_decision_out;
	endproperty
	a_preset_clears: assert property (p_preset_clears) else $error("decision not cleared");
	// limit stands through preset and the release that reads the decision
	property p_limit_kept;
		$fell(latch_preset_n) |-> limit_value == $past(limit_value, 4) ##4 (latch_preset_n && $stable(limit_value))[*4];
	endproperty
	a_limit_kept: assert property (p_limit_kept) else $error("limit not held");
	property p_cycle_len;
		$rose(converter_on) |-> ##49 converter_on ##1 !converter_on;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("check length wrong");

	// ==========================================================
	// coverage of the main scenarios
	c_start: cover property ($rose(converter_on));
	c_high: cover property ($rose(sar_decision_out));
	c_preset: cover property ($fell(latch_preset_n));
endmodule : scan_adc_assertions
`default_nettype wire

// ===== verif/adc_scan_limit_check_control_tb.sv
// self-checking bench: controller and converter ends joined by the scan interface
`timescale 1ns/1ps
`default_nettype none
module adc_scan_limit_check_control_tb;
	// ==========================================================
	// stimulus and observed signals
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;           // dropped once to show a frozen write
	logic [7:0]  addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [31:0] rd_data;
	logic [79:0] channel_levels = 80'h0;
	logic [9:0]  held_level;
	logic [1:0]  ref_source;
	logic [2:0]  minus_pick;
	logic        pass_gate_on, probe_drive, minus_contention, warm;
	logic        rd_taken = 1'b0;     // read accepted at the last edge
	logic [31:0] exp_q[$];            // expected read data, oldest first
	int          fails = 0;
	int          tests_run = 0;

	always #10 clk = ~clk;

	// ==========================================================
	// both ends and the checker on their common interface
	converter_scan_if link_if ();
	scan_check_controller scan_check_controller_inst (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if.ctrl),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
	converter_scan_end converter_scan_end_inst (.clk(clk), .rstn(rstn), .ce(ce), .link(link_if.conv),
		.channel_levels(channel_levels), .held_level(held_level), .ref_source(ref_source), .minus_pick(minus_pick),
		.pass_gate_on(pass_gate_on), .probe_drive(probe_drive), .minus_contention(minus_contention), .warm(warm));
	scan_adc_assertions scan_adc_assertions_inst (.clk(clk), .rstn(rstn),
		.sample_freeze(link_if.sample_freeze), .latch_preset_n(link_if.latch_preset_n),
		.channel_select_onehot(link_if.channel_select_onehot), .minus_input_pick(link_if.minus_input_pick),
		.bandgap_dac_ref_on(link_if.bandgap_dac_ref_on), .supply_ref_pick(link_if.supply_ref_pick),
		.gain_bypass_gate(link_if.gain_bypass_gate), .gain_power_on(link_if.gain_power_on),
		.settle_boost(link_if.settle_boost), .gain_switch_clk(link_if.gain_switch_clk),
		.gain_path_on(link_if.gain_path_on), .bandgap_minus_on(link_if.bandgap_minus_on),
		.ground_minus_on(link_if.ground_minus_on), .converter_on(link_if.converter_on),
		.switchcap_probe_en(link_if.switchcap_probe_en), .limit_value(link_if.limit_value),
		.sar_decision_out(link_if.sar_decision_out));

	// ==========================================================
	// comparison, verdict and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// strobes stay up between calls so transfers can run back to back
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		exp_q.push_back(exp);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic idle(input int n);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	// converter side outputs while the controller rests
	task automatic check_idle();
		check(ref_source, scan_adc_pkg::REF_EXTERNAL, "reference");
		check(minus_pick, scan_adc_pkg::IDLE_MINUS, "minus mux");
		check(pass_gate_on, 1'b1, "pass gate");
		check({probe_drive, minus_contention, warm}, 3'h0, "probe, contention, warm");
	endtask : check_idle

	// ==========================================================
	// read monitor: data stand only in the cycle after the strobe
	always @(posedge clk) rd_taken <= rd_en & rstn;
	always @(negedge clk) begin
		if (rd_taken) begin
			check(rd_data, exp_q.pop_front(), "read data");
		end
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		$display("FAIL %0t watchdog expired", $time);
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		int          lvl, ch, lo, hi, st;
		logic [79:0] lv;
		int          dl[6] = '{-5, 1, -5, 0, -16, -1};
		int          dh[6] = '{5, 5, 0, 1, 23, -1};
		void'($urandom(58318));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// reset values, write-only start and an unmapped address
		rd(scan_adc_pkg::CHANNEL_OFS, 32'h0);
		rd(scan_adc_pkg::LOW_OFS, 32'h0);
		rd(scan_adc_pkg::HIGH_OFS, 32'h3ff);
		rd(scan_adc_pkg::STATUS_OFS, 32'h0);
		rd(scan_adc_pkg::CTRL_OFS, 32'h0);
		wr(8'h14, $urandom);
		rd(8'h14, 32'h0);
		// a write with the clock enable low must not land
		ce <= 1'b0;
		wr(scan_adc_pkg::LOW_OFS, 32'h155);
		ce <= 1'b1;
		rd(scan_adc_pkg::LOW_OFS, 32'h0);
		idle(2);
		check_idle();
		// limit checks: pass, each limit failing and the boundaries
		for (int i = 0; i < 6; i++) begin
			ch = $urandom_range(7, 0);
			lvl = $urandom_range(1000, 16);
			lo = lvl + dl[i];
			hi = lvl + dh[i];
			lv = 80'({$urandom, $urandom, $urandom});
			lv[ch*10 +: 10] = 10'(lvl);
			channel_levels <= lv;
			wr(scan_adc_pkg::CHANNEL_OFS, 32'(ch));
			wr(scan_adc_pkg::LOW_OFS, 32'(lo));
			wr(scan_adc_pkg::HIGH_OFS, 32'(hi));
			rd(scan_adc_pkg::CHANNEL_OFS, 32'(ch));
			rd(scan_adc_pkg::LOW_OFS, 32'(lo));
			rd(scan_adc_pkg::HIGH_OFS, 32'(hi));
			wr(scan_adc_pkg::CTRL_OFS, 32'h1);
			rd(scan_adc_pkg::STATUS_OFS, 32'h1);
			// both of these must be ignored while busy
			wr(scan_adc_pkg::CHANNEL_OFS, 32'(ch ^ 1));
			wr(scan_adc_pkg::CTRL_OFS, 32'h1);
			idle(20);
			check(warm, 1'b1, "warm");
			idle(35);
			st = ((hi > lvl) << 4) | ((lo <= lvl) << 3) | (((lo <= lvl) && (hi > lvl)) << 2) | 2;
			rd(scan_adc_pkg::STATUS_OFS, 32'(st));
			rd(scan_adc_pkg::CHANNEL_OFS, 32'(ch));
			idle(2);
			check(held_level, 32'(lvl), "held level");
			check_idle();
		end
		idle(2);
		conclude();
	end
endmodule : adc_scan_limit_check_control_tb
`default_nettype wire
